// ---- bench/tb_top.sv ----
// Self-checking bench for the startup delay unlock block
`timescale 1ns/100ps
module tb_top;
   import sdu_pkg::*;
   // Shortened counts for simulation
   localparam int unsigned UNIT = 10;
   localparam int unsigned SLOW = 4;
   localparam int unsigned FAST = 2;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   sdu_req_s req = '0;
   logic [31:0] rdata;
   logic [11:0] nv_delay = 12'h000;
   logic nv_wr;
   logic [11:0] nv_data;
   logic mode_sw = 1'b0;
   logic led;
   logic init;
   int n_fail = 0;
   int samples_checked = 0;
   int n = 0;
   int tg[$];
   logic [31:0] rv;

   //----------------------------------------
   // Clock and design
   //----------------------------------------
   always #10 ref_clk_i = ~ref_clk_i;

   sdu_startup_delay #(.UNIT_CYCLES(UNIT), .SLOW_HALF(SLOW),
      .FAST_HALF(FAST)) i_dut (
      .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .bus_req_i(req),
      .bus_rdata_o(rdata), .nv_delay_i(nv_delay), .nv_wr_o(nv_wr),
      .nv_data_o(nv_data), .operating_mode_switch_i(mode_sw),
      .boot_status_led_o(led), .io_bus_init_o(init));

   //----------------------------------------
   // Helper tasks
   //----------------------------------------
   // Compare seen against expected and count
   task automatic check(input string what, input logic [31:0] seen,
                        input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Verdict and end of run
   task automatic stop_test();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : stop_test

   // One-cycle write strobe
   task automatic reg_wr(input logic [21:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge ref_clk_i);
      req.wr <= 1'b0;
      #1;
   endtask : reg_wr

   // One-cycle read strobe, data in the following cycle
   task automatic reg_rd(input logic [21:0] a);
      @(posedge ref_clk_i);
      req <= '{addr: a, wdata: 32'h00000000, wr: 1'b0, rd: 1'b1};
      @(posedge ref_clk_i);
      req.rd <= 1'b0;
      #1;
      rv = rdata;
   endtask : reg_rd

   // Reset with a stored delay and a switch position
   task automatic boot(input logic [11:0] nv, input logic sw);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b0;
      nv_delay <= nv;
      mode_sw <= sw;
      @(posedge ref_clk_i);
      #1;
      check("init in reset", {31'h0, init}, 32'h0);
      check("led in reset", {31'h0, led}, 32'h0);
      @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
   endtask : boot

   // Bounded wait for bus init, logging led toggle cycles
   task automatic wait_init(input int lim);
      logic last;
      n = 0;
      last = 1'b0;
      tg = {};
      while (init !== 1'b1 && n < lim) begin
         @(posedge ref_clk_i);
         #1;
         n++;
         if (led !== last) begin
            tg.push_back(n);
         end
         last = led;
      end
      if (init !== 1'b1) begin
         n_fail++;
         $display("[FAIL] bus init timeout after %0d cycles", n);
         stop_test();
      end
   endtask : wait_init

   //----------------------------------------
   // Main sequence
   //----------------------------------------
   initial begin
      // Timed boot: two units with the switch in run
      boot(12'h002, 1'b1);
      wait_init(2 * UNIT + 40);
      check("wait length ok", {31'h0, n >= 24 && n <= 27}, 32'h1);
      if (tg.size() < 4) begin
         check("led toggles", tg.size(), 32'h4);
      end else begin
         check("slow half", tg[1] - tg[0], SLOW);
         check("fast half", tg[$] - tg[$-1], FAST);
      end
      check("led off after", {31'h0, led}, 32'h0);
      reg_rd(ADDR_DELAY);
      check("delay from store", rv, 32'h00000002);
      reg_rd(ADDR_STATUS);
      check("status done", rv, 32'h00000002);
      $display("test timed_boot done");
      // Locked write, range refusal, accepted write
      reg_wr(ADDR_DELAY, 32'h00000005);
      check("locked nv write", {31'h0, nv_wr}, 32'h0);
      reg_rd(ADDR_DELAY);
      check("locked delay", rv, 32'h00000002);
      reg_wr(ADDR_UNLOCK, UNLOCK_KEY);
      reg_rd(ADDR_UNLOCK);
      check("key held", rv, UNLOCK_KEY);
      reg_wr(ADDR_DELAY, 32'h00000BB9);
      check("over range nv", {31'h0, nv_wr}, 32'h0);
      reg_rd(ADDR_UNLOCK);
      check("key kept", rv, UNLOCK_KEY);
      reg_wr(ADDR_DELAY, 32'h00000BB8);
      check("nv strobe", {31'h0, nv_wr}, 32'h1);
      check("nv data", {20'h0, nv_data}, 32'h00000BB8);
      reg_rd(ADDR_UNLOCK);
      check("key cleared", rv, 32'h00000000);
      reg_rd(ADDR_DELAY);
      check("delay max", rv, 32'h00000BB8);
      reg_rd(ADDR_STATUS + 22'h4);
      check("unmapped read", rv, 32'h00000000);
      $display("test unlock done");
      // Switch leaves run during the wait
      boot(12'h005, 1'b1);
      repeat (12) @(posedge ref_clk_i);
      #1;
      check("init held", {31'h0, init}, 32'h0);
      reg_rd(ADDR_STATUS);
      check("status waiting", rv, 32'h00000001);
      repeat (22) @(posedge ref_clk_i);
      reg_rd(ADDR_STATUS);
      check("status fast", rv, 32'h00000005);
      @(posedge ref_clk_i);
      mode_sw <= 1'b0;
      wait_init(6);
      check("abort length", n, 32'h00000003);
      $display("test abort done");
      // Switch not in run at boot
      boot(12'h005, 1'b0);
      wait_init(8);
      check("stop_mode length", n, 32'h00000004);
      check("no blink", tg.size(), 32'h0);
      $display("test stop_mode done");
      // Zero delay skips the wait
      boot(12'h000, 1'b1);
      wait_init(8);
      check("zero delay length", n, 32'h00000004);
      $display("test zero_delay done");
      stop_test();
   end
endmodule : tb_top

// ---- hdl/sdu_startup_delay.sv ----
// Startup delay sequencer with unlock key and remanent delay register
`timescale 1ns/100ps
module sdu_startup_delay
   import sdu_pkg::*;
#(
   parameter int unsigned UNIT_CYCLES = UNIT_CYC,
   parameter int unsigned SLOW_HALF = SLOW_HALF_CYC,
   parameter int unsigned FAST_HALF = FAST_HALF_CYC
) (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Register port
   input wire sdu_req_s bus_req_i,
   output logic [31:0] bus_rdata_o,
   // Nonvolatile store
   input wire logic [11:0] nv_delay_i,
   output logic nv_wr_o,
   output logic [11:0] nv_data_o,
   // Mode switch pin and boot outputs
   input wire logic operating_mode_switch_i,
   output logic boot_status_led_o,
   output logic io_bus_init_o
);

   //------------------------------------------------------------
   // Switch synchroniser
   //------------------------------------------------------------
   logic run_meta;
   logic run_sync;

   // Two flops before any logic
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         run_meta <= 1'b0;
         run_sync <= 1'b0;
      end else begin
         run_meta <= operating_mode_switch_i;
         run_sync <= run_meta;
      end
   end

   //------------------------------------------------------------
   // Register decode
   //------------------------------------------------------------
   logic [31:0] unlock_key;
   logic [11:0] boot_delay;
   sdu_state_e state;
   logic fast_phase;
   wire sel_unlock = (bus_req_i.addr == ADDR_UNLOCK);
   wire sel_delay = (bus_req_i.addr == ADDR_DELAY);
   wire sel_status = (bus_req_i.addr == ADDR_STATUS);
   wire key_ok = (unlock_key == UNLOCK_KEY);
   wire in_range = (bus_req_i.wdata <= {20'h00000, DELAY_MAX});
   wire delay_take = bus_req_i.wr && sel_delay && key_ok && in_range;
   wire [31:0] status_word = {29'h0, fast_phase && state == ST_WAIT,
      state == ST_DONE, state == ST_WAIT};
   wire [31:0] next_rdata = !bus_req_i.rd ? 32'h00000000 :
      sel_unlock ? unlock_key :
      sel_delay ? {20'h00000, boot_delay} :
      sel_status ? status_word : 32'h00000000;

   // Unlock register: key stored, cleared by accepted delay write
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unlock_key <= UNLOCK_RESET;
      end else if (delay_take) begin
         unlock_key <= UNLOCK_RESET;
      end else if (bus_req_i.wr && sel_unlock) begin
         unlock_key <= bus_req_i.wdata;
      end
   end

   // Read data, one cycle after the strobe
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         bus_rdata_o <= 32'h00000000;
      end else begin
         bus_rdata_o <= next_rdata;
      end
   end

   //------------------------------------------------------------
   // Delay register and nonvolatile write-through
   //------------------------------------------------------------
   logic [1:0] settle;
   wire [11:0] nv_clamped = (nv_delay_i > DELAY_MAX) ? DELAY_MAX : nv_delay_i;

   // Load from store after reset, guarded writes afterwards
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         boot_delay <= DELAY_RESET;
         nv_wr_o <= 1'b0;
         nv_data_o <= DELAY_RESET;
      end else begin
         nv_wr_o <= delay_take;
         if (delay_take) begin
            boot_delay <= bus_req_i.wdata[11:0];
            nv_data_o <= bus_req_i.wdata[11:0];
         end else if (state == ST_LOAD && settle == 2'h0) begin
            boot_delay <= nv_clamped;
         end
      end
   end

   //------------------------------------------------------------
   // Boot sequencer
   //------------------------------------------------------------
   logic [11:0] target;
   logic [11:0] units;
   logic [22:0] unit_cnt;
   logic [24:0] blink_cnt;
   wire unit_end = (unit_cnt == 23'(UNIT_CYCLES - 1));
   wire wait_end = (units == target);
   wire [24:0] half_len = fast_phase ? 25'(FAST_HALF) : 25'(SLOW_HALF);
   wire blink_end = (blink_cnt >= half_len - 25'h0000001);
   wire settled = (settle == SETTLE_CYC);
   wire start_wait = settled && run_sync && (target != 12'h000);
   assign fast_phase = ({units, 1'b0} >= {1'b0, target});
   assign io_bus_init_o = (state == ST_DONE);

   // Settle counter lets the switch pass the synchroniser
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         settle <= 2'h0;
      end else if (state == ST_LOAD && !settled) begin
         settle <= settle + 2'h1;
      end
   end

   // State transitions
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state <= ST_LOAD;
      end else begin
         case (state)
            ST_LOAD: begin
               if (start_wait) begin
                  state <= ST_WAIT;
               end else if (settled) begin
                  state <= ST_DONE;
               end
            end
            ST_WAIT: begin
               if (!run_sync || wait_end) begin
                  state <= ST_DONE;
               end
            end
            ST_DONE: state <= ST_DONE;
            default: state <= ST_LOAD;
         endcase
      end
   end

   // Target captured once per boot; later writes serve the next boot
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         target <= DELAY_RESET;
      end else if (state == ST_LOAD && settle == 2'h1) begin
         target <= boot_delay;
      end
   end

   // Unit timer: one unit per 100 ms
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         unit_cnt <= 23'h000000;
         units <= 12'h000;
      end else if (state == ST_WAIT) begin
         unit_cnt <= unit_end ? 23'h000000 : unit_cnt + 23'h000001;
         if (unit_end) begin
            units <= units + 12'h001;
         end
      end
   end

   // Status LED blinker, half period by phase
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         blink_cnt <= 25'h0000000;
         boot_status_led_o <= 1'b0;
      end else if (state == ST_WAIT) begin
         blink_cnt <= blink_end ? 25'h0000000 : blink_cnt + 25'h0000001;
         if (blink_end) begin
            boot_status_led_o <= !boot_status_led_o;
         end
      end else begin
         blink_cnt <= 25'h0000000;
         boot_status_led_o <= 1'b0;
      end
   end

   //------------------------------------------------------------
   // Assertions
   //------------------------------------------------------------
   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_n_i);

   chk_key_clear: assert property (
      delay_take |=> unlock_key == UNLOCK_RESET)
      else $error("unlock key not cleared after delay write");

   chk_locked_write: assert property (
      bus_req_i.wr && sel_delay && !key_ok && state != ST_LOAD
      |=> $stable(boot_delay))
      else $error("delay changed without key");

   chk_delay_range: assert property (
      boot_delay <= DELAY_MAX)
      else $error("delay register above maximum");

   chk_nv_store: assert property (
      delay_take |=> nv_wr_o && nv_data_o == $past(bus_req_i.wdata[11:0]))
      else $error("store write missing or wrong");

   chk_no_run_skip: assert property (
      state == ST_LOAD && settled && !run_sync |=> state == ST_DONE)
      else $error("delay started outside run");

   chk_run_abort: assert property (
      state == ST_WAIT && !run_sync |=> state == ST_DONE && io_bus_init_o)
      else $error("delay not ended on leaving run");

   chk_hold_init: assert property (
      state == ST_WAIT && !wait_end && run_sync |=> !io_bus_init_o)
      else $error("bus init before delay end");

   chk_unit_step: assert property (
      state == ST_WAIT && unit_end && run_sync && !wait_end
      |=> units == $past(units) + 12'h001 && unit_cnt == 23'h000000)
      else $error("unit counter step wrong");

   chk_blink_slow: assert property (
      state == ST_WAIT && !fast_phase && run_sync && !wait_end
      && blink_cnt == 25'(SLOW_HALF - 1)
      |=> boot_status_led_o != $past(boot_status_led_o))
      else $error("slow blink toggle missing");

   chk_blink_fast: assert property (
      state == ST_WAIT && fast_phase && run_sync && !wait_end
      && blink_cnt == 25'(FAST_HALF - 1)
      |=> boot_status_led_o != $past(boot_status_led_o))
      else $error("fast blink toggle missing");

   //------------------------------------------------------------
   // Register port and sequencing assertions
   //------------------------------------------------------------
   // Key write lands unless a delay write clears it
   chk_key_write: assert property (
      bus_req_i.wr && sel_unlock |=> unlock_key == $past(bus_req_i.wdata))
      else $error("unlock key write lost");

   // Out-of-range write leaves delay and key alone
   chk_range_refuse: assert property (
      bus_req_i.wr && sel_delay && key_ok && !in_range && state != ST_LOAD
      |=> $stable(boot_delay) && $stable(unlock_key))
      else $error("out-of-range delay write accepted");

   // Store strobe only after an accepted delay write
   chk_nv_pulse: assert property (
      !delay_take |=> !nv_wr_o)
      else $error("store strobe without accepted write");

   // Stored delay taken at boot when in range
   chk_load_delay: assert property (
      state == ST_LOAD && settle == 2'h0 && !delay_take
      && nv_delay_i <= DELAY_MAX |=> boot_delay == $past(nv_delay_i))
      else $error("stored delay not loaded");

   // Read data zero outside a read
   chk_rdata_idle: assert property (
      !bus_req_i.rd |=> bus_rdata_o == 32'h00000000)
      else $error("read data not zero outside a read");

   chk_rdata_delay: assert property (
      bus_req_i.rd && sel_delay
      |=> bus_rdata_o == {20'h00000, $past(boot_delay)})
      else $error("delay read data wrong");

   // Wait starts clean and ends on the last unit
   chk_wait_start: assert property (
      state == ST_LOAD && start_wait
      |=> state == ST_WAIT && units == 12'h000 && unit_cnt == 23'h000000)
      else $error("wait entry not clean");

   chk_wait_exit: assert property (
      state == ST_WAIT && wait_end |=> state == ST_DONE)
      else $error("wait not ended at programmed delay");

   // Target latched for this boot, init released for good
   chk_target_latch: assert property (
      state != ST_LOAD |=> $stable(target))
      else $error("boot target changed after load");

   chk_init_hold: assert property (
      io_bus_init_o |=> io_bus_init_o)
      else $error("bus init withdrawn");

   // Status LED dark outside the wait
   chk_led_idle: assert property (
      state != ST_WAIT |=> !boot_status_led_o)
      else $error("status LED lit outside the wait");

   cov_full_wait: cover property (
      state == ST_WAIT && wait_end && run_sync);
   cov_abort: cover property (state == ST_WAIT && !run_sync);
   cov_unlock_write: cover property (delay_take);
   cov_fast_phase: cover property (state == ST_WAIT && fast_phase);
   cov_range_refuse: cover property (bus_req_i.wr && sel_delay && !in_range);

endmodule : sdu_startup_delay

// ---- include/sdu_pkg.sv ----
// Constants and types for the startup delay unlock block
//------------------------------------------------------------
// Summary of operation
// - Delay register value counts boot delay in 100 ms units.
// - On next boot, wait the programmed delay before I/O bus init.
// - Accepted delay write after correct key clears the unlock register.
// - Delay accepts 0 (off) up to 3000 units, 300 seconds.
// - Delay value kept in nonvolatile storage across resets.
// - Boot delay runs only with the mode switch in run at boot.
// - Leaving run while counting ends the delay at once.
// - First half of delay: status LED blinks slowly, about 1 Hz.
// - Second half of delay: status LED blinks fast, about 4 Hz.
//------------------------------------------------------------
package sdu_pkg;
   // Register indices; byte address is four times the index
   localparam logic [19:0] IDX_UNLOCK = 20'h318DA;
   localparam logic [19:0] IDX_DELAY = 20'h318DB;
   localparam logic [19:0] IDX_STATUS = 20'h318DC;
   localparam logic [21:0] ADDR_UNLOCK = {IDX_UNLOCK, 2'b00};
   localparam logic [21:0] ADDR_DELAY = {IDX_DELAY, 2'b00};
   localparam logic [21:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
   // Register values
   localparam logic [31:0] UNLOCK_KEY = 32'h424F6F74;
   localparam logic [31:0] UNLOCK_RESET = 32'h00000000;
   localparam logic [11:0] DELAY_MAX = 12'hBB8;
   localparam logic [11:0] DELAY_RESET = 12'h000;
   // Status fields
   localparam int STAT_WAIT_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_FAST_BIT = 2;
   // Timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned UNIT_MS = 100;
   localparam int unsigned SLOW_HZ = 1;
   localparam int unsigned FAST_HZ = 4;
   localparam int unsigned UNIT_CYC = CLK_HZ / 1000 * UNIT_MS;
   localparam int unsigned SLOW_HALF_CYC = CLK_HZ / (2 * SLOW_HZ);
   localparam int unsigned FAST_HALF_CYC = CLK_HZ / (2 * FAST_HZ);
   localparam logic [1:0] SETTLE_CYC = 2'h3;
   // Register port request
   typedef struct packed {
      logic [21:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } sdu_req_s;
   // Boot sequencer states
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_WAIT = 2'b01,
      ST_DONE = 2'b10
   } sdu_state_e;
endpackage : sdu_pkg
